// ==== rtl/pace_vbat_leadoff_regs.svh ====
// register offsets, field positions and reset values of the lead-off and routing bank
`ifndef PACE_VBAT_LEADOFF_REGS_SVH
`define PACE_VBAT_LEADOFF_REGS_SVH

`define PACE_ROUTING_IDX 4'h4
`define BATMON_ROUTING_IDX 4'h5
`define LEADOFF_MODE_IDX 4'h6
`define LEADOFF_ENABLE_IDX 4'h7

`define PACE_ROUTING_RST 8'h00
`define BATMON_ROUTING_RST 8'h00
`define LEADOFF_MODE_RST 8'h08
`define LEADOFF_ENABLE_RST 8'h00

`define PACE_ROUTING_MASK 8'hff
`define BATMON_ROUTING_MASK 8'h07
`define LEADOFF_MODE_MASK 8'h1f
`define LEADOFF_ENABLE_MASK 8'h3f

`define PACE_TEST_MSB 7
`define PACE_TEST_LSB 6
`define PACE_POS_MSB 5
`define PACE_POS_LSB 3
`define PACE_NEG_MSB 2
`define PACE_NEG_LSB 0
`define LEADOFF_AC_METHOD_BIT 4
`define LEADOFF_SHUTDOWN_BIT 3
`define LEADOFF_AC_SELECT_BIT 2
`define LEADOFF_LEVEL_MSB 1
`define LEADOFF_LEVEL_LSB 0

`endif

// ==== rtl/pace_vbat_leadoff_pkg.sv ====
// types shared by the configuration bank and its decoder
package pace_vbat_leadoff_pkg;
	typedef enum logic [1:0] {
		TEST_NONE,
		TEST_POSITIVE,
		TEST_NEGATIVE,
		TEST_ZERO
	} pace_test_t;

	typedef enum logic [1:0] {
		LEADOFF_OFF,
		LEADOFF_DC,
		LEADOFF_AC_ANALOG,
		LEADOFF_AC_DIGITAL
	} leadoff_mode_t;

	typedef struct packed {
		logic [7:0] paceRouting;
		logic [7:0] batmonRouting;
		logic [7:0] leadoffMode;
		logic [7:0] leadoffEnable;
	} cfg_t;
endpackage : pace_vbat_leadoff_pkg

// ==== rtl/cfg_bus_if.sv ====
// carries the stored configuration from the register bank to the decoder
`timescale 1ns/100ps
`default_nettype none
interface cfg_bus_if;
	pace_vbat_leadoff_pkg::cfg_t cfg;
	modport bank (output cfg);
	modport decode (input cfg);
endinterface : cfg_bus_if
`default_nettype wire

// ==== rtl/config_decode.sv ====
// turns stored configuration into switch and detector controls
`timescale 1ns/100ps
`default_nettype none
`include "pace_vbat_leadoff_regs.svh"
module config_decode (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// stored configuration
	cfg_bus_if.decode cfgIn,
	// decoded controls
	output var pace_vbat_leadoff_pkg::pace_test_t paceTest,
	output logic [6:1] pacePosSel,
	output logic [6:1] paceNegSel,
	output logic [2:0] batmonOverride,
	output var pace_vbat_leadoff_pkg::leadoff_mode_t leadoffMode,
	output logic [1:0] acTriggerLevel,
	output logic [6:1] leadoffPinEnable,
	output logic [2:0] leadoffChanEnable,
	output logic [2:0] leadoffChanCurrent
);
	typedef struct packed {
		pace_vbat_leadoff_pkg::pace_test_t test;
		logic [6:1] pos;
		logic [6:1] neg;
		logic [2:0] bat;
		pace_vbat_leadoff_pkg::leadoff_mode_t mode;
		logic [1:0] lvl;
		logic [6:1] pin;
		logic [2:0] chan;
		logic [2:0] cur;
	} dec_t;
	dec_t state_r;
	dec_t state_nxt;
	logic [2:0] posCode;
	logic [2:0] negCode;
	logic [7:0] lm;
	logic [7:0] le;
	logic [6:1] posHot;
	logic [6:1] negHot;

	assign posCode = cfgIn.cfg.paceRouting[`PACE_POS_MSB:`PACE_POS_LSB];
	assign negCode = cfgIn.cfg.paceRouting[`PACE_NEG_MSB:`PACE_NEG_LSB];
	assign lm = cfgIn.cfg.leadoffMode;
	assign le = cfgIn.cfg.leadoffEnable;

	////////////////////////////////////////////////////////////////////////
	// one-hot input selection; 000 and 111 leave the terminal open
	genvar gi;
	generate
		for (gi = 1; gi <= 6; gi++) begin : g_sel
			assign posHot[gi] = (posCode == 3'(gi)); // RL3
			assign negHot[gi] = (negCode == 3'(gi)); // RL4
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// next decoded state
	always_comb begin
		state_nxt = '0;
		state_nxt.test = pace_vbat_leadoff_pkg::pace_test_t'(
			cfgIn.cfg.paceRouting[`PACE_TEST_MSB:`PACE_TEST_LSB]); // RL2
		// a test signal replaces terminal routing, so switches open
		if (state_nxt.test == pace_vbat_leadoff_pkg::TEST_NONE) begin // RL1
			state_nxt.pos = posHot;
			state_nxt.neg = negHot;
		end
		state_nxt.bat = cfgIn.cfg.batmonRouting[2:0]; // RL5 RL6
		state_nxt.lvl = lm[`LEADOFF_LEVEL_MSB:`LEADOFF_LEVEL_LSB]; // RL11
		if (lm[`LEADOFF_SHUTDOWN_BIT]) begin // RL9
			state_nxt.mode = pace_vbat_leadoff_pkg::LEADOFF_OFF;
		end else if (!lm[`LEADOFF_AC_SELECT_BIT]) begin // RL10
			state_nxt.mode = pace_vbat_leadoff_pkg::LEADOFF_DC;
		end else if (lm[`LEADOFF_AC_METHOD_BIT]) begin // RL8
			state_nxt.mode = pace_vbat_leadoff_pkg::LEADOFF_AC_ANALOG;
		end else begin
			state_nxt.mode = pace_vbat_leadoff_pkg::LEADOFF_AC_DIGITAL;
		end
		case (state_nxt.mode)
			pace_vbat_leadoff_pkg::LEADOFF_DC,
			pace_vbat_leadoff_pkg::LEADOFF_AC_ANALOG: begin
				state_nxt.pin = le[5:0]; // RL13
			end
			pace_vbat_leadoff_pkg::LEADOFF_AC_DIGITAL: begin
				state_nxt.chan = le[2:0]; // RL14
				state_nxt.cur = le[5:3]; // RL12
			end
			default: begin
				state_nxt.pin = '0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// registered so the analog switches see glitch-free levels
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign paceTest = state_r.test;
	assign pacePosSel = state_r.pos;
	assign paceNegSel = state_r.neg;
	assign batmonOverride = state_r.bat;
	assign leadoffMode = state_r.mode;
	assign acTriggerLevel = state_r.lvl;
	assign leadoffPinEnable = state_r.pin;
	assign leadoffChanEnable = state_r.chan;
	assign leadoffChanCurrent = state_r.cur;

	////////////////////////////////////////////////////////////////////////
	// checks
	property p_testOpensSwitches;
		@(posedge mclk) disable iff (rst)
		(state_r.test != pace_vbat_leadoff_pkg::TEST_NONE) |-> (state_r.pos == '0 && state_r.neg == '0);
	endproperty
	a_testOpensSwitches: assert property (p_testOpensSwitches) else $error("test select left switches closed"); // RL1

	property p_offClearsEnables;
		@(posedge mclk) disable iff (rst)
		(state_r.mode == pace_vbat_leadoff_pkg::LEADOFF_OFF) |-> (state_r.pin == '0 && state_r.chan == '0);
	endproperty
	a_offClearsEnables: assert property (p_offClearsEnables) else $error("lead-off enables active in shutdown"); // RL9
endmodule : config_decode
`default_nettype wire

// ==== rtl/config_bank.sv ====
// stores the four configuration registers behind an axi4-lite slave
`timescale 1ns/100ps
`default_nettype none
`include "pace_vbat_leadoff_regs.svh"
module config_bank (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// register bus
	cfg_bus_if.bank cfgOut,
	input wire logic [3:0] regIdx,
	input wire logic [7:0] wrData,
	input wire logic [3:0] wrStrb,
	input wire logic wrEn,
	input wire logic [3:0] rdIdx,
	output logic [7:0] rdData,
	output logic rdHit,
	output logic wrHit
);
	pace_vbat_leadoff_pkg::cfg_t state_r;
	pace_vbat_leadoff_pkg::cfg_t state_nxt;

	////////////////////////////////////////////////////////////////////////
	// write path; only lane 0 carries data, reserved bits masked
	always_comb begin
		state_nxt = state_r;
		if (wrEn && wrStrb[0]) begin
			case (regIdx)
				`PACE_ROUTING_IDX: state_nxt.paceRouting = wrData & `PACE_ROUTING_MASK; // RL15
				`BATMON_ROUTING_IDX: state_nxt.batmonRouting = wrData & `BATMON_ROUTING_MASK; // RL15
				`LEADOFF_MODE_IDX: state_nxt.leadoffMode = wrData & `LEADOFF_MODE_MASK; // RL15
				`LEADOFF_ENABLE_IDX: state_nxt.leadoffEnable = wrData & `LEADOFF_ENABLE_MASK; // RL15
				default: state_nxt = state_r;
			endcase
		end
	end

	// defaults: no test, switches open, monitor off, lead-off shut down
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_r.paceRouting <= `PACE_ROUTING_RST; // RL1 RL3 RL4
			state_r.batmonRouting <= `BATMON_ROUTING_RST; // RL5
			state_r.leadoffMode <= `LEADOFF_MODE_RST; // RL8 RL9 RL10 RL11
			state_r.leadoffEnable <= `LEADOFF_ENABLE_RST; // RL12 RL13 RL14
		end else begin
			state_r <= state_nxt;
		end
	end

	assign cfgOut.cfg = state_r;
	assign wrHit = (regIdx >= `PACE_ROUTING_IDX) && (regIdx <= `LEADOFF_ENABLE_IDX);
	assign rdHit = (rdIdx >= `PACE_ROUTING_IDX) && (rdIdx <= `LEADOFF_ENABLE_IDX);

	// read mux
	always_comb begin
		case (rdIdx)
			`PACE_ROUTING_IDX: rdData = state_r.paceRouting;
			`BATMON_ROUTING_IDX: rdData = state_r.batmonRouting;
			`LEADOFF_MODE_IDX: rdData = state_r.leadoffMode;
			`LEADOFF_ENABLE_IDX: rdData = state_r.leadoffEnable;
			default: rdData = 8'h00;
		endcase
	end

	property p_reservedZero;
		@(posedge mclk) disable iff (rst)
		(state_r.batmonRouting[7:3] == 5'h00) && (state_r.leadoffMode[7:5] == 3'h0) && (state_r.leadoffEnable[7:6] == 2'h0);
	endproperty
	a_reservedZero: assert property (p_reservedZero) else $error("reserved bit became set"); // RL15

	property p_writeStores;
		@(posedge mclk) disable iff (rst)
		(wrEn && wrStrb[0] && regIdx == `BATMON_ROUTING_IDX) |=> (state_r.batmonRouting == ($past(wrData) & 8'h07));
	endproperty
	a_writeStores: assert property (p_writeStores) else $error("monitor routing write lost"); // RL5
endmodule : config_bank
`default_nettype wire

// ==== rtl/pace_vbat_leadoff_config_regs.sv ====
// top: axi4-lite slave, configuration bank and control decoder
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "pace_vbat_leadoff_regs.svh"
// Summary of operation
// RL1: pace test field 00 means routing only
// RL2: 01 positive, 10 negative, 11 zero test
// RL3: positive terminal 000 open, 1-6 IN1-IN6
// RL4: negative terminal 000 open, 1-6 IN1-IN6
// RL5: one monitor enable bit per channel, default off
// RL6: monitor bit overrides channel routing while set
// RL7: software shuts channel amplifier before monitoring
// RL8: ac method bit: 0 digital, 1 analog
// RL9: shutdown bit resets 1; 0 activates detection
// RL10: operation bit: 0 dc, 1 ac
// RL11: two-bit ac trigger level, default level 0
// RL12: digital ac: bits 3-5 set channel current
// RL13: dc or analog ac: bit per input pin
// RL14: digital ac: bits 0-2 enable channels
// RL15: eight-bit registers, reserved read zero, writes ignored
module pace_vbat_leadoff_config_regs (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// axi4-lite write address
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// pace channel switches
	output var pace_vbat_leadoff_pkg::pace_test_t paceTest,
	output logic [6:1] pacePosSel,
	output logic [6:1] paceNegSel,
	// battery monitor override per channel
	output logic [2:0] batmonOverride,
	// lead-off detector controls
	output var pace_vbat_leadoff_pkg::leadoff_mode_t leadoffMode,
	output logic [1:0] acTriggerLevel,
	output logic [6:1] leadoffPinEnable,
	output logic [2:0] leadoffChanEnable,
	output logic [2:0] leadoffChanCurrent
);
	typedef struct packed {
		logic awHeld;
		logic [3:0] awIdx;
		logic wHeld;
		logic [7:0] wByte;
		logic [3:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic rValid;
		logic [7:0] rByte;
		logic [1:0] rResp;
	} axi_t;
	axi_t state_r;
	axi_t state_nxt;
	logic wrFire;
	logic rdFire;
	logic [7:0] rdData;
	logic rdHit;
	logic wrHit;
	logic aligned;
	logic rdAligned;

	cfg_bus_if cfgBus ();

	////////////////////////////////////////////////////////////////////////
	// channel readiness: one write and one read in flight at most
	assign s_axi_awready = !state_r.awHeld && !state_r.bValid;
	assign s_axi_wready = !state_r.wHeld && !state_r.bValid;
	assign s_axi_arready = !state_r.rValid;
	assign wrFire = state_r.awHeld && state_r.wHeld && !state_r.bValid;
	assign rdFire = s_axi_arvalid && s_axi_arready;
	assign aligned = (state_r.awIdx != 4'hf);
	assign rdAligned = (s_axi_araddr[1:0] == 2'h0);

	////////////////////////////////////////////////////////////////////////
	// slave state update
	always_comb begin
		state_nxt = state_r;
		// address and data may come in either order; each is latched on its own
		if (s_axi_awvalid && s_axi_awready) begin
			state_nxt.awHeld = 1'b1;
			state_nxt.awIdx = (s_axi_awaddr[1:0] == 2'h0) ? s_axi_awaddr[5:2] : 4'hf;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			state_nxt.wHeld = 1'b1;
			state_nxt.wByte = s_axi_wdata[7:0];
			state_nxt.wStrb = s_axi_wstrb;
		end
		if (wrFire) begin
			state_nxt.awHeld = 1'b0;
			state_nxt.wHeld = 1'b0;
			state_nxt.bValid = 1'b1;
			state_nxt.bResp = (wrHit && aligned) ? 2'h0 : 2'h2;
		end
		if (state_r.bValid && s_axi_bready) begin
			state_nxt.bValid = 1'b0;
		end
		// reads answer one cycle after the address is taken
		if (rdFire) begin
			state_nxt.rValid = 1'b1;
			state_nxt.rByte = (rdHit && rdAligned) ? rdData : 8'h00; // RL15
			state_nxt.rResp = (rdHit && rdAligned) ? 2'h0 : 2'h2;
		end else if (state_r.rValid && s_axi_rready) begin
			state_nxt.rValid = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign s_axi_bvalid = state_r.bValid;
	assign s_axi_bresp = state_r.bResp;
	assign s_axi_rvalid = state_r.rValid;
	assign s_axi_rresp = state_r.rResp;
	assign s_axi_rdata = {24'h000000, state_r.rByte}; // RL15

	////////////////////////////////////////////////////////////////////////
	// register storage; misaligned writes never reach it
	config_bank u_bank (
		.mclk(mclk),
		.rst(rst),
		.cfgOut(cfgBus.bank),
		.regIdx(state_r.awIdx),
		.wrData(state_r.wByte),
		.wrStrb(state_r.wStrb),
		.wrEn(wrFire && aligned),
		.rdIdx(s_axi_araddr[5:2]),
		.rdData(rdData),
		.rdHit(rdHit),
		.wrHit(wrHit)
	);

	// decoded controls for the analog side
	config_decode u_decode (
		.mclk(mclk),
		.rst(rst),
		.cfgIn(cfgBus.decode),
		.paceTest(paceTest),
		.pacePosSel(pacePosSel),
		.paceNegSel(paceNegSel),
		.batmonOverride(batmonOverride), // RL6
		.leadoffMode(leadoffMode),
		.acTriggerLevel(acTriggerLevel),
		.leadoffPinEnable(leadoffPinEnable),
		.leadoffChanEnable(leadoffChanEnable),
		.leadoffChanCurrent(leadoffChanCurrent)
	);

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_writeDone;
		wrFire ##1 s_axi_bvalid;
	endsequence

	property p_writeResponds;
		@(posedge mclk) disable iff (rst)
		wrFire |-> ##1 s_axi_bvalid;
	endproperty
	a_writeResponds: assert property (p_writeResponds) else $error("write response missing"); // RL15

	property p_bHeld;
		@(posedge mclk) disable iff (rst)
		(s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid;
	endproperty
	a_bHeld: assert property (p_bHeld) else $error("bvalid dropped early"); // RL15

	property p_readResponds;
		@(posedge mclk) disable iff (rst)
		rdFire |=> (s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000);
	endproperty
	a_readResponds: assert property (p_readResponds) else $error("read answer late or padded"); // RL15

	property p_monitorWrite;
		@(posedge mclk) disable iff (rst)
		(wrFire && aligned && state_r.awIdx == `BATMON_ROUTING_IDX && state_r.wStrb[0]) |-> ##2
			(batmonOverride == $past(state_r.wByte[2:0], 2));
	endproperty
	a_monitorWrite: assert property (p_monitorWrite) else $error("monitor override not following write"); // RL6

	property p_pacePos;
		@(posedge mclk) disable iff (rst)
		s_writeDone ##1 (paceTest == pace_vbat_leadoff_pkg::TEST_NONE) |-> ($countones(pacePosSel) <= 1);
	endproperty
	a_pacePos: assert property (p_pacePos) else $error("more than one positive switch closed"); // RL3

	property p_paceNeg;
		@(posedge mclk) disable iff (rst)
		(paceTest == pace_vbat_leadoff_pkg::TEST_NONE) |-> ($countones(paceNegSel) <= 1);
	endproperty
	a_paceNeg: assert property (p_paceNeg) else $error("more than one negative switch closed"); // RL4

	property p_digitalNoPins;
		@(posedge mclk) disable iff (rst)
		(leadoffMode == pace_vbat_leadoff_pkg::LEADOFF_AC_DIGITAL) |-> (leadoffPinEnable == '0);
	endproperty
	a_digitalNoPins: assert property (p_digitalNoPins) else $error("pin enables active in digital ac"); // RL14

	property p_pinNoChan;
		@(posedge mclk) disable iff (rst)
		(leadoffMode == pace_vbat_leadoff_pkg::LEADOFF_DC) |-> (leadoffChanEnable == '0 && leadoffChanCurrent == '0);
	endproperty
	a_pinNoChan: assert property (p_pinNoChan) else $error("channel enables active in dc"); // RL13
endmodule : pace_vbat_leadoff_config_regs
`default_nettype wire

// ==== verif/pace_vbat_leadoff_config_regs_tb.sv ====
// self-checking bench for the pace, battery-monitor and lead-off configuration bank
`timescale 1ns/100ps
`default_nettype none
`include "pace_vbat_leadoff_regs.svh"
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin nFail++; \
	$display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module pace_vbat_leadoff_config_regs_tb;
	localparam logic [5:0] A_PACE = {`PACE_ROUTING_IDX, 2'b00};
	localparam logic [5:0] A_BAT = {`BATMON_ROUTING_IDX, 2'b00};
	localparam logic [5:0] A_MODE = {`LEADOFF_MODE_IDX, 2'b00};
	localparam logic [5:0] A_EN = {`LEADOFF_ENABLE_IDX, 2'b00};
	logic mclk, rst;
	logic [5:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, acTriggerLevel, r;
	pace_vbat_leadoff_pkg::pace_test_t paceTest;
	pace_vbat_leadoff_pkg::leadoff_mode_t leadoffMode;
	logic [6:1] pacePosSel, paceNegSel, leadoffPinEnable;
	logic [2:0] batmonOverride, leadoffChanEnable, leadoffChanCurrent;
	logic [31:0] d;
	int nFail = 0;
	int comparisons = 0;
	int cycles = 0;
	int i;
	pace_vbat_leadoff_config_regs pace_vbat_leadoff_config_regs_inst (.mclk(mclk), .rst(rst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .paceTest(paceTest),
		.pacePosSel(pacePosSel), .paceNegSel(paceNegSel), .batmonOverride(batmonOverride),
		.leadoffMode(leadoffMode), .acTriggerLevel(acTriggerLevel), .leadoffPinEnable(leadoffPinEnable),
		.leadoffChanEnable(leadoffChanEnable), .leadoffChanCurrent(leadoffChanCurrent));

	////////////////////////////////////////////////////////////////////////////////
	// 50 MHz clock and a hang guard well above the few hundred cycles the tests need
	always #10 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			nFail++;
			tally_and_finish();
		end
	end

	task tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, nFail);
		if (nFail == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite write: address and data offered together, each dropped once taken
	// bready rises only after bWait edges, so a response left waiting must stand
	task axiWrite(input logic [5:0] a, input logic [31:0] wd, input logic [3:0] st, input int bWait,
		output logic [1:0] resp);
		logic bDone;
		int n;
		bDone = 1'b0;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= wd;
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= (bWait == 0);
		while (!bDone) begin
			@(posedge mclk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				resp = s_axi_bresp;
				bDone = 1'b1;
				s_axi_bready <= 1'b0;
			end else if (n >= bWait) begin
				s_axi_bready <= 1'b1;
			end
		end
		// one idle edge so a following call never reassigns in this time step
		@(posedge mclk);
	endtask : axiWrite

	// axi4-lite read: rready held until the data beat is taken
	task axiRead(input logic [5:0] a, output logic [31:0] rd, output logic [1:0] resp);
		logic rDone;
		rDone = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!rDone) begin
			@(posedge mclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) begin
				rd = s_axi_rdata;
				resp = s_axi_rresp;
				rDone = 1'b1;
				s_axi_rready <= 1'b0;
			end
		end
		@(posedge mclk);
	endtask : axiRead

	// register write, then a few edges for the decoded controls to follow
	task wr(input logic [5:0] a, input logic [7:0] v);
		axiWrite(a, {24'h0, v}, 4'hf, 0, r);
		`CHECK(r, 2'h0)
		repeat (4) @(posedge mclk);
	endtask : wr

	task checkReg(input logic [5:0] a, input logic [7:0] v);
		axiRead(a, d, r);
		`CHECK(r, 2'h0)
		`CHECK(d, {24'h0, v})
	endtask : checkReg

	task checkDefaults();
		checkReg(A_PACE, 8'h00);
		checkReg(A_BAT, 8'h00);
		checkReg(A_MODE, 8'h08);
		checkReg(A_EN, 8'h00);
		`CHECK(paceTest, pace_vbat_leadoff_pkg::TEST_NONE)
		`CHECK(pacePosSel, 6'h00)
		`CHECK(paceNegSel, 6'h00)
		`CHECK(batmonOverride, 3'h0)
		`CHECK(leadoffMode, pace_vbat_leadoff_pkg::LEADOFF_OFF)
		`CHECK(acTriggerLevel, 2'h0)
		$display("test defaults done");
	endtask : checkDefaults

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		checkDefaults();
		// every input on both terminals, negative one running the other way
		for (i = 1; i <= 6; i++) begin
			wr(A_PACE, {2'b00, 3'(i), 3'(7 - i)});
			`CHECK(pacePosSel, 6'(6'h01 << (i - 1)))
			`CHECK(paceNegSel, 6'(6'h01 << (6 - i)))
			checkReg(A_PACE, {2'b00, 3'(i), 3'(7 - i)});
		end
		// test signals must open the routed switches
		for (i = 1; i <= 3; i++) begin
			wr(A_PACE, {2'(i), 3'h2, 3'h5});
			`CHECK(paceTest, pace_vbat_leadoff_pkg::pace_test_t'(i))
			`CHECK(pacePosSel, 6'h00)
			`CHECK(paceNegSel, 6'h00)
		end
		// code 111 on both terminals leaves them open
		wr(A_PACE, 8'h3f);
		`CHECK(pacePosSel, 6'h00)
		`CHECK(paceNegSel, 6'h00)
		wr(A_PACE, 8'h15);
		`CHECK(paceTest, pace_vbat_leadoff_pkg::TEST_NONE)
		`CHECK(pacePosSel, 6'h02)
		`CHECK(paceNegSel, 6'h10)
		$display("test pace routing done");
		// battery monitor bits, reserved upper bits dropped; the bench acts as software
		// whose channel amplifiers are already shut down elsewhere
		wr(A_BAT, 8'hff);
		`CHECK(batmonOverride, 3'h7)
		checkReg(A_BAT, 8'h07);
		wr(A_BAT, 8'h05);
		`CHECK(batmonOverride, 3'h5)
		wr(A_BAT, 8'h02);
		`CHECK(batmonOverride, 3'h2)
		$display("test battery monitor done");
		// lead-off: enables held while shut down, then each mode
		wr(A_EN, 8'hff);
		checkReg(A_EN, 8'h3f);
		`CHECK(leadoffMode, pace_vbat_leadoff_pkg::LEADOFF_OFF)
		`CHECK(leadoffPinEnable, 6'h00)
		wr(A_MODE, 8'he0);
		checkReg(A_MODE, 8'h00);
		`CHECK(leadoffMode, pace_vbat_leadoff_pkg::LEADOFF_DC)
		`CHECK(leadoffPinEnable, 6'h3f)
		`CHECK(leadoffChanEnable, 3'h0)
		wr(A_MODE, 8'h14);
		`CHECK(leadoffMode, pace_vbat_leadoff_pkg::LEADOFF_AC_ANALOG)
		`CHECK(leadoffChanEnable, 3'h0)
		`CHECK(leadoffPinEnable, 6'h3f)
		wr(A_EN, 8'h29);
		wr(A_MODE, 8'h04);
		`CHECK(leadoffMode, pace_vbat_leadoff_pkg::LEADOFF_AC_DIGITAL)
		`CHECK(leadoffChanEnable, 3'h1)
		`CHECK(leadoffChanCurrent, 3'h5)
		`CHECK(leadoffPinEnable, 6'h00)
		for (i = 0; i < 4; i++) begin
			wr(A_MODE, {6'h01, 2'(i)});
			`CHECK(acTriggerLevel, 2'(i))
		end
		wr(A_MODE, 8'h0c);
		`CHECK(leadoffMode, pace_vbat_leadoff_pkg::LEADOFF_OFF)
		`CHECK(leadoffChanEnable, 3'h0)
		$display("test lead-off done");
		// unmapped and misaligned places answer with an error and change nothing
		for (i = 0; i < 4; i++) begin
			d = (i == 0) ? 32'h00 : (i == 1) ? 32'h0c : (i == 2) ? 32'h11 : 32'h20;
			axiWrite(d[5:0], 32'hffff_ffff, 4'hf, 0, r);
			`CHECK(r, 2'h2)
			axiRead(d[5:0], d, r);
			`CHECK(r, 2'h2)
			`CHECK(d, 32'h0)
		end
		checkReg(A_PACE, 8'h15);
		axiWrite(A_BAT, 32'h0000_0007, 4'h0, 4, r);
		`CHECK(r, 2'h0)
		checkReg(A_BAT, 8'h02);
		$display("test refusals done");
		// second reset in mid-run restores every default
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		checkDefaults();
		tally_and_finish();
	end
endmodule : pace_vbat_leadoff_config_regs_tb
`default_nettype wire
